// File: mpmux_top.v
`include "mpmux_defines.vh"

module mpmux_top #(
    parameter WAIT_W = 4
) (
    input wire I_CORE_CLK,
    input wire I_RESET,
    input wire i_MODE_STRAP,
    input wire i_ACK_CFG_STRAP,
    input wire i_XREQ,
    input wire i_XWRITE,
    input wire [1:0] i_XSPACE,
    input wire [13:0] i_XADDR,
    input wire [7:0] i_XBYTE_HI,
    input wire [23:0] i_XWDATA,
    input wire [WAIT_W-1:0] i_WAIT_STATES,
    output wire o_XBUSY,
    output reg o_XDONE,
    output reg [23:0] o_XRDATA,
    output wire o_HOST_MODE,
    input wire [13:0] i_ADDR_PIN,
    output wire [13:0] o_ADDR_PIN,
    output wire [13:0] o_ADDR_PIN_OE_N,
    input wire [23:0] i_DATA_PIN,
    output wire [23:0] o_DATA_PIN,
    output wire [23:0] o_DATA_PIN_OE_N,
    output wire o_PROGRAM_MEM_SELECT_N,
    output wire o_DATA_MEM_SELECT_N,
    output wire o_BYTE_MEM_SELECT_N,
    output wire o_IO_SPACE_SELECT_N,
    output wire o_COMBINED_MEM_SELECT_N,
    output wire o_RD_N,
    output wire o_WR_N,
    output wire o_IMEM_REQ,
    output wire o_IMEM_WE,
    output wire o_IMEM_SPACE,
    output wire [13:0] o_IMEM_ADDR,
    output wire [15:0] o_IMEM_WDATA,
    input wire [15:0] i_IMEM_RDATA,
    input wire i_IMEM_READY
);
    // External access states.
    localparam ST_IDLE = 1'b0;
    localparam ST_ACCESS = 1'b1;

    reg mode; // Latched operating mode.
    reg ack_mode; // Latched acknowledge behaviour.
    reg state; // External access state.
    reg [WAIT_W-1:0] wait_cnt; // Remaining wait states.
    reg acc_write; // Access direction.
    reg [1:0] acc_space; // Space of the access in flight.
    reg [13:0] acc_addr; // Registered external address.
    reg [7:0] acc_byte_hi; // Registered byte address high part.
    reg [23:0] acc_wdata; // Registered write data.
    reg [23:0] next_rdata; // Read word assembled from the pins.
    wire host_mode; // High in host mode.
    wire is_byte; // Byte space access in flight.
    wire active; // Strobes asserted.
    wire [15:0] iad_in; // Host bus as seen on the shared pins.
    wire [15:0] iad_out; // Word the host port returns.
    wire iad_drive; // Host port drives the bus.
    wire ack; // Acknowledge asserted.
    reg [13:0] addr_out; // Address pin values.
    reg [13:0] addr_oe_n; // Address pin enables.
    reg [23:0] data_out; // Data pin values.
    reg [23:0] data_oe_n; // Data pin enables.

    // Returns true when the access in flight targets the given space.
    function sel_hit;
        input act;
        input [1:0] space;
        input [1:0] code;
        begin
            sel_hit = act & (space == code);
        end
    endfunction

    // Straps are caught by the clock while reset is held; no async reset here,
    // since an async reset may only load a constant and the strap is a level.
    always @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            mode <= i_MODE_STRAP;
            ack_mode <= i_ACK_CFG_STRAP;
        end
    end

    assign host_mode = (mode == `MPM_MODE_HOST);
    assign o_HOST_MODE = host_mode & ~I_RESET;
    assign is_byte = (acc_space == `MPM_SPACE_BYTE);
    assign active = (state == ST_ACCESS);
    assign o_XBUSY = active;

    // Selects and strobes; in host mode outside logic decodes peripherals from these and the lowest line.
    assign o_PROGRAM_MEM_SELECT_N = ~sel_hit(active, acc_space, `MPM_SPACE_PROG);
    assign o_DATA_MEM_SELECT_N = ~sel_hit(active, acc_space, `MPM_SPACE_DATA);
    assign o_BYTE_MEM_SELECT_N = ~sel_hit(active, acc_space, `MPM_SPACE_BYTE);
    assign o_IO_SPACE_SELECT_N = ~sel_hit(active, acc_space, `MPM_SPACE_IO);
    // The combined select covers every space but byte memory.
    assign o_COMBINED_MEM_SELECT_N = ~(active & ~is_byte);
    assign o_RD_N = ~(active & ~acc_write);
    assign o_WR_N = ~(active & acc_write);

    // Host port signals sit on the shared pins only in host mode.
    assign iad_in = {i_DATA_PIN[2:0], i_ADDR_PIN[13:1]};

    // Core access sequencer: one strobe cycle plus wait states on slow spaces.
    always @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state <= ST_IDLE;
            wait_cnt <= {WAIT_W{1'b0}};
            acc_write <= 1'b0;
            acc_space <= `MPM_SPACE_PROG;
            acc_addr <= {14{1'b0}};
            acc_byte_hi <= {8{1'b0}};
            acc_wdata <= {24{1'b0}};
            o_XDONE <= 1'b0;
            o_XRDATA <= {24{1'b0}};
        end else begin
            o_XDONE <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Requests while busy are not taken; the source watches the busy flag.
                    if (i_XREQ) begin
                        acc_write <= i_XWRITE;
                        acc_space <= i_XSPACE;
                        acc_addr <= i_XADDR;
                        acc_byte_hi <= i_XBYTE_HI;
                        acc_wdata <= i_XWDATA;
                        if ((i_XSPACE == `MPM_SPACE_BYTE) || (i_XSPACE == `MPM_SPACE_IO)) begin
                            wait_cnt <= i_WAIT_STATES;
                        end else begin
                            // Fast spaces finish in the first strobe cycle.
                            wait_cnt <= {WAIT_W{1'b0}};
                        end
                        state <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (wait_cnt == {WAIT_W{1'b0}}) begin
                        if (!acc_write) begin
                            o_XRDATA <= next_rdata;
                        end
                        o_XDONE <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read word from the pins; host mode only has the upper sixteen lines.
    always @* begin
        next_rdata = {24{1'b0}};
        if (!host_mode) begin
            if (is_byte) begin
                next_rdata[7:0] = i_DATA_PIN[7:0];
            end else begin
                next_rdata = i_DATA_PIN;
            end
        end else begin
            if (is_byte) begin
                next_rdata[7:0] = i_DATA_PIN[15:8];
            end else begin
                next_rdata[23:8] = i_DATA_PIN[23:8];
            end
        end
    end

    // Pin multiplexer: every shared pin takes one function, the other stays idle.
    always @* begin
        addr_out = {14{1'b0}};
        addr_oe_n = {14{1'b1}};
        data_out = {24{1'b0}};
        data_oe_n = {24{1'b1}};
        if (I_RESET) begin
            // All shared pins float until reset is released.
            addr_oe_n = {14{1'b1}};
            data_oe_n = {24{1'b1}};
        end else if (!host_mode) begin
            addr_out = acc_addr;
            addr_oe_n = {14{1'b0}};
            if (active & is_byte) begin
                // Top lines carry byte address bits for a 4 MB reach.
                data_out[23:16] = acc_byte_hi;
                data_oe_n[23:16] = {8{1'b0}};
                if (acc_write) begin
                    data_out[7:0] = acc_wdata[7:0];
                    data_oe_n[7:0] = {8{1'b0}};
                end
            end else if (active & acc_write) begin
                data_out = acc_wdata;
                data_oe_n = {24{1'b0}};
            end
        end else begin
            addr_out[0] = acc_addr[0];
            addr_oe_n[0] = 1'b0;
            if (iad_drive) begin
                addr_out[13:1] = iad_out[`MPM_IAD_LO_MSB:0];
                addr_oe_n[13:1] = {13{1'b0}};
                data_out[2:0] = iad_out[15:`MPM_IAD_HI_LSB];
                data_oe_n[2:0] = {3{1'b0}};
            end
            // Open drain: pulls low when asserted, floats otherwise.
            data_out[`MPM_PIN_ACK] = 1'b0;
            data_oe_n[`MPM_PIN_ACK] = ~ack;
            if (active & is_byte) begin
                data_out[23:16] = acc_byte_hi;
                data_oe_n[23:16] = {8{1'b0}};
                if (acc_write) begin
                    data_out[15:8] = acc_wdata[7:0];
                    data_oe_n[15:8] = {8{1'b0}};
                end
            end else if (active & acc_write) begin
                data_out[23:8] = acc_wdata[23:8];
                data_oe_n[23:8] = {16{1'b0}};
            end
        end
    end

    assign o_ADDR_PIN = addr_out;
    assign o_ADDR_PIN_OE_N = addr_oe_n;
    assign o_DATA_PIN = data_out;
    assign o_DATA_PIN_OE_N = data_oe_n;

    // Host port engine; disabled in full memory mode so its strobes are ignored.
    mpmux_hostport #(
        .ADDR_W(14),
        .DATA_W(16)
    ) u_hostport (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RESET),
        .i_enable(host_mode),
        .i_ack_mode(ack_mode),
        .i_iad(iad_in),
        .i_sel_n(i_DATA_PIN[`MPM_PIN_SEL]),
        .i_ale(i_DATA_PIN[`MPM_PIN_ALE]),
        .i_rd_n(i_DATA_PIN[`MPM_PIN_RD]),
        .i_wr_n(i_DATA_PIN[`MPM_PIN_WR]),
        .o_iad(iad_out),
        .o_iad_drive(iad_drive),
        .o_ack(ack),
        .o_mem_req(o_IMEM_REQ),
        .o_mem_we(o_IMEM_WE),
        .o_mem_space(o_IMEM_SPACE),
        .o_mem_addr(o_IMEM_ADDR),
        .o_mem_wdata(o_IMEM_WDATA),
        .i_mem_rdata(i_IMEM_RDATA),
        .i_mem_ready(i_IMEM_READY)
    );
endmodule // mpmux_top

// File: mpmux_defines.vh
// Behaviour
// - Mode strap caught in reset, then fixed.
// - Strap low selects full memory mode.
// - Strap high selects host port mode.
// - Full mode drives fourteen external address lines.
// - Full mode 24-bit data; byte address high.
// - Host mode has 16-bit shared address/data bus.
// - Host mode keeps lowest address, upper data.
// - Open-drain acknowledge, behaviour set by strap.
// - Each shared pin carries only current mode.
// - Host reaches on-chip memory without processor.
// - Byte port reaches four megabytes both ways in full mode; host mode addresses with only A0 and the top eight data lines.
// - Program and data buses share external buses.
// - Programmable wait states on byte, I/O spaces.
`ifndef MPMUX_DEFINES_VH
`define MPMUX_DEFINES_VH

// Operating modes as read from the strap.
`define MPM_MODE_FULL 1'b0
`define MPM_MODE_HOST 1'b1

// Acknowledge behaviour as read from the second strap.
`define MPM_ACK_LEVEL 1'b0
`define MPM_ACK_PULSE 1'b1

// External access spaces.
`define MPM_SPACE_PROG 2'h0
`define MPM_SPACE_DATA 2'h1
`define MPM_SPACE_BYTE 2'h2
`define MPM_SPACE_IO 2'h3

// Host port memory space select bit values.
`define MPM_HSPACE_PROG 1'b0
`define MPM_HSPACE_DATA 1'b1

// Data pin positions that carry host port signals in host mode.
`define MPM_PIN_ACK 3
`define MPM_PIN_SEL 4
`define MPM_PIN_ALE 5
`define MPM_PIN_RD 6
`define MPM_PIN_WR 7

// Host bus split: low part on address pins 13:1, top part on data pins 2:0.
`define MPM_IAD_LO_MSB 12
`define MPM_IAD_HI_LSB 13
`define MPM_IAD_SPACE_BIT 14

// Byte address high part sits on the top eight data lines.
`define MPM_BYTE_HI_LSB 16

// Wait counter reload for single-cycle spaces.
`define MPM_NO_WAIT 0

`endif

// File: mpmux_hostport.v
`include "mpmux_defines.vh"

module mpmux_hostport #(
    parameter ADDR_W = 14,
    parameter DATA_W = 16
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_enable,
    input wire i_ack_mode,
    input wire [DATA_W-1:0] i_iad,
    input wire i_sel_n,
    input wire i_ale,
    input wire i_rd_n,
    input wire i_wr_n,
    output wire [DATA_W-1:0] o_iad,
    output wire o_iad_drive,
    output wire o_ack,
    output wire o_mem_req,
    output reg o_mem_we,
    output reg o_mem_space,
    output reg [ADDR_W-1:0] o_mem_addr,
    output reg [DATA_W-1:0] o_mem_wdata,
    input wire [DATA_W-1:0] i_mem_rdata,
    input wire i_mem_ready
);
    // Port states.
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_WRITE = 2'b10;

    reg [1:0] state; // Current port state.
    reg rd_q; // Read strobe one cycle ago.
    reg wr_q; // Write strobe one cycle ago.
    reg [DATA_W-1:0] rdata; // Last word fetched from memory.
    reg ack_pulse; // One-cycle completion pulse.
    wire rd_fall; // Start of a host read.
    wire wr_rise; // End of a host write, data is stable here.

    // The host strobes are synchronous, so a single delay stage is enough for edges.
    assign rd_fall = i_enable & ~i_sel_n & ~i_rd_n & rd_q;
    assign wr_rise = i_enable & ~i_sel_n & i_wr_n & ~wr_q;
    assign o_mem_req = (state != ST_IDLE);

    // Drive the bus only while the host reads and the word is ready.
    assign o_iad = rdata;
    assign o_iad_drive = i_enable & ~i_sel_n & ~i_rd_n & (state == ST_IDLE) & ~rd_q;

    // Level style acknowledges readiness; pulse style marks each completion.
    assign o_ack = i_enable & ((i_ack_mode == `MPM_ACK_PULSE) ? ack_pulse : (~i_sel_n & (state == ST_IDLE)));

    // Strobe history, address latch and transfer sequencing.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            rdata <= {DATA_W{1'b0}};
            ack_pulse <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_space <= `MPM_HSPACE_PROG;
            o_mem_addr <= {ADDR_W{1'b0}};
            o_mem_wdata <= {DATA_W{1'b0}};
        end else begin
            rd_q <= i_rd_n;
            wr_q <= i_wr_n;
            ack_pulse <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Strobes while busy are ignored; the host waits on the acknowledge.
                    if (i_enable & ~i_sel_n & i_ale) begin
                        o_mem_addr <= i_iad[ADDR_W-1:0];
                        o_mem_space <= i_iad[`MPM_IAD_SPACE_BIT];
                    end else if (rd_fall) begin
                        o_mem_we <= 1'b0;
                        state <= ST_READ;
                    end else if (wr_rise) begin
                        o_mem_we <= 1'b1;
                        o_mem_wdata <= i_iad;
                        state <= ST_WRITE;
                    end
                end
                ST_READ: begin
                    // Memory answers without the processor taking part.
                    if (i_mem_ready) begin
                        rdata <= i_mem_rdata;
                        o_mem_addr <= o_mem_addr + 1'b1;
                        ack_pulse <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    // Address advances so a block moves with one latch.
                    if (i_mem_ready) begin
                        o_mem_we <= 1'b0;
                        o_mem_addr <= o_mem_addr + 1'b1;
                        ack_pulse <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // mpmux_hostport

// File: mpmux_asserts.sv
module mpmux_asserts #(
    parameter WAIT_W = 4
) (
    input wire I_CORE_CLK,
    input wire I_RESET,
    input wire i_MODE_STRAP,
    input wire i_XREQ,
    input wire [1:0] i_XSPACE,
    input wire [WAIT_W-1:0] i_WAIT_STATES,
    input wire o_XBUSY,
    input wire o_XDONE,
    input wire o_HOST_MODE,
    input wire [13:0] o_ADDR_PIN_OE_N,
    input wire [23:0] o_DATA_PIN,
    input wire [23:0] o_DATA_PIN_OE_N,
    input wire o_PROGRAM_MEM_SELECT_N,
    input wire o_DATA_MEM_SELECT_N,
    input wire o_BYTE_MEM_SELECT_N,
    input wire o_IO_SPACE_SELECT_N,
    input wire o_RD_N,
    input wire o_WR_N,
    input wire o_IMEM_REQ,
    input wire [13:0] o_IMEM_ADDR,
    input wire i_IMEM_READY
);
    default clocking @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);
    // An access starts only when the core asks and the bus is free.
    wire take = i_XREQ && !o_XBUSY;
    // Byte and I/O spaces are the slow ones that take wait states.
    wire slow = i_XSPACE[1];
    a_reset_float: assert property (disable iff (1'b0) I_RESET |-> &o_ADDR_PIN_OE_N && &o_DATA_PIN_OE_N)
        else $error("pins driven during reset");
    a_mode_fixed: assert property ($past(!I_RESET) |-> $stable(o_HOST_MODE))
        else $error("mode changed without reset");
    a_mode_strap: assert property ($fell(I_RESET) |-> o_HOST_MODE == $past(i_MODE_STRAP))
        else $error("mode differs from strap");
    a_fast_done: assert property (take && !slow |-> ##2 o_XDONE)
        else $error("fast access done at wrong time");
    a_wait_done: assert property (take && slow |-> ##1 !o_XDONE ##[1:16] o_XDONE)
        else $error("slow access done out of range");
    a_one_space: assert property ($onehot0(~{o_PROGRAM_MEM_SELECT_N, o_DATA_MEM_SELECT_N,
        o_BYTE_MEM_SELECT_N, o_IO_SPACE_SELECT_N}))
        else $error("two space selects active");
    a_full_addr: assert property (!o_HOST_MODE && !(o_RD_N && o_WR_N) |-> o_ADDR_PIN_OE_N == 14'h0000)
        else $error("address lines not driven");
    a_host_upper: assert property (o_HOST_MODE && !o_WR_N |-> o_DATA_PIN_OE_N[23:8] == 16'h0000 && !o_ADDR_PIN_OE_N[0])
        else $error("host mode write pins not driven");
    a_host_ctl_in: assert property (o_HOST_MODE |-> &o_DATA_PIN_OE_N[7:4])
        else $error("host strobe pin driven");
    a_full_no_imem: assert property (!o_HOST_MODE |-> !o_IMEM_REQ)
        else $error("host port active in full mode");
    a_ack_drain: assert property (o_HOST_MODE && !o_DATA_PIN_OE_N[3] |-> !o_DATA_PIN[3])
        else $error("acknowledge driven high");
    a_imem_hold: assert property (o_IMEM_REQ && !i_IMEM_READY |=> o_IMEM_REQ && $stable(o_IMEM_ADDR))
        else $error("memory request dropped early");
    c_slow_wait: cover property (take && slow && i_WAIT_STATES != 0);
    c_imem_done: cover property (o_IMEM_REQ && i_IMEM_READY);
    c_ack_seen: cover property (o_HOST_MODE && !o_DATA_PIN_OE_N[3]);
endmodule // mpmux_asserts

bind mpmux_top mpmux_asserts #(.WAIT_W(WAIT_W)) mpmux_asserts_i (.I_CORE_CLK, .I_RESET, .i_XREQ, .i_XSPACE,
    .i_WAIT_STATES, .o_XBUSY, .o_XDONE, .o_HOST_MODE, .o_ADDR_PIN_OE_N, .o_DATA_PIN, .o_DATA_PIN_OE_N,
    .o_PROGRAM_MEM_SELECT_N, .o_DATA_MEM_SELECT_N, .o_BYTE_MEM_SELECT_N, .o_IO_SPACE_SELECT_N,
    .o_RD_N, .o_WR_N, .o_IMEM_REQ, .o_IMEM_ADDR, .i_IMEM_READY, .i_MODE_STRAP);

// File: mpmux_host_model.sv
module mpmux_host_model (
    input wire logic clk,
    input wire logic ack_n,
    input wire logic [15:0] bus_in,
    output logic sel_n,
    output logic ale,
    output logic rd_n,
    output logic wr_n,
    output logic [15:0] bus_out,
    output logic bus_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // The host starts idle with every strobe inactive and the bus released.
    initial begin
        sel_n = 1'b1;
        ale = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        bus_out = 16'h0000;
        bus_oe = 1'b0;
    end
    // Waits for the engine to leave idle, then for the acknowledge; this works for both ack styles.
    task automatic wait_ack();
        int n;
        n = 0;
        while (ack_n === 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        while (ack_n !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask
    // Address phase: select stays low for the whole stream that follows.
    task automatic latch(input logic [15:0] v);
        sel_n = 1'b0;
        ale = 1'b1;
        bus_out = v;
        bus_oe = 1'b1;
        @(negedge clk);
        ale = 1'b0;
        bus_oe = 1'b0;
        @(negedge clk);
    endtask
    // Data is held through the edge that first sees the write strobe high.
    task automatic wr(input logic [15:0] v);
        bus_out = v;
        bus_oe = 1'b1;
        wr_n = 1'b0;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        bus_oe = 1'b0;
        wait_ack();
    endtask
    // The bus is only sampled once the acknowledge says the word is there.
    task automatic rd(output logic [15:0] v);
        rd_n = 1'b0;
        @(negedge clk);
        wait_ack();
        v = bus_in;
        rd_n = 1'b1;
        @(negedge clk);
    endtask
endmodule // mpmux_host_model

// File: memory_port_mode_mux_tb.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, a, e); end end
module memory_port_mode_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_CORE_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic i_MODE_STRAP = 1'b0;
    logic i_ACK_CFG_STRAP = 1'b0;
    logic i_XREQ = 1'b0;
    logic i_XWRITE = 1'b0;
    logic [1:0] i_XSPACE = 2'h0;
    logic [13:0] i_XADDR = 14'h0000;
    logic [7:0] i_XBYTE_HI = 8'h00;
    logic [23:0] i_XWDATA = 24'h00_0000;
    logic [3:0] i_WAIT_STATES = 4'h0;
    logic [15:0] i_IMEM_RDATA = 16'h0000;
    logic i_IMEM_READY = 1'b0;
    wire o_XBUSY, o_XDONE, o_HOST_MODE, o_RD_N, o_WR_N, o_IMEM_REQ, o_IMEM_WE, o_IMEM_SPACE;
    wire o_PROGRAM_MEM_SELECT_N, o_DATA_MEM_SELECT_N, o_BYTE_MEM_SELECT_N, o_IO_SPACE_SELECT_N;
    wire o_COMBINED_MEM_SELECT_N;
    wire [23:0] o_XRDATA, o_DATA_PIN, o_DATA_PIN_OE_N, i_DATA_PIN;
    wire [13:0] o_ADDR_PIN, o_ADDR_PIN_OE_N, o_IMEM_ADDR, i_ADDR_PIN;
    wire [15:0] o_IMEM_WDATA;
    logic h_sel_n, h_ale, h_rd_n, h_wr_n, h_oe;
    logic [15:0] h_out;
    logic hm = 1'b0;
    logic [23:0] ext_rd = 24'h00_0000;
    logic [31:0] last = 32'h0000_0000;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    // Outside levels: host strobes on D7:4, pulled-up ack on D3, memory data elsewhere; A pins float inverted.
    wire [23:0] d_far = hm ? {ext_rd[23:8], h_wr_n, h_rd_n, h_ale, h_sel_n, 1'b1,
        h_oe ? h_out[15:13] : ext_rd[2:0]} : ext_rd;
    wire [13:0] a_far = h_oe ? {h_out[12:0], ~o_ADDR_PIN[0]} : ~o_ADDR_PIN;
    assign i_DATA_PIN = (o_DATA_PIN & ~o_DATA_PIN_OE_N) | (d_far & o_DATA_PIN_OE_N);
    assign i_ADDR_PIN = (o_ADDR_PIN & ~o_ADDR_PIN_OE_N) | (a_far & o_ADDR_PIN_OE_N);
    wire [3:0] sel_v = {o_IO_SPACE_SELECT_N, o_BYTE_MEM_SELECT_N, o_DATA_MEM_SELECT_N, o_PROGRAM_MEM_SELECT_N};
    mpmux_top #(.WAIT_W(4)) mpmux_top_i (.*);
    mpmux_host_model mpmux_host_model_i (.clk(I_CORE_CLK), .ack_n(i_DATA_PIN[3]),
        .bus_in({i_DATA_PIN[2:0], i_ADDR_PIN[13:1]}), .sel_n(h_sel_n), .ale(h_ale), .rd_n(h_rd_n),
        .wr_n(h_wr_n), .bus_out(h_out), .bus_oe(h_oe));
    always #12.5 I_CORE_CLK = ~I_CORE_CLK;
    // On-chip memory answers after a random delay and records what it was asked.
    always @(negedge I_CORE_CLK) begin
        i_IMEM_READY = o_IMEM_REQ && !i_IMEM_READY && ($urandom_range(1) == 1);
        if (i_IMEM_READY)
            last = {o_IMEM_WE, o_IMEM_SPACE, o_IMEM_ADDR, o_IMEM_WDATA};
    end
    // A hang is cut short well past the few hundred cycles the run needs.
    always @(posedge I_CORE_CLK) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    function automatic int exp_cyc(input logic [1:0] sp, input logic [3:0] w);
        return sp[1] ? 1 + w : 1;
    endfunction
    function automatic logic [3:0] exp_sel(input logic [1:0] sp);
        return ~(4'h1 << sp);
    endfunction
    // Reset with both straps set; the pins must float until release.
    task automatic do_reset(input logic m, input logic a);
        i_MODE_STRAP = m;
        i_ACK_CFG_STRAP = a;
        hm = m;
        I_RESET = 1'b1;
        repeat (2) @(negedge I_CORE_CLK);
        `CHK({o_ADDR_PIN_OE_N, o_DATA_PIN_OE_N}, 38'h3f_ffff_ffff)
        I_RESET = 1'b0;
        @(negedge I_CORE_CLK);
        `CHK(o_HOST_MODE, m)
    endtask
    // One core access; pins are checked in the first and last select cycles.
    task automatic xacc(input logic wr, input logic [1:0] sp, input logic [3:0] w);
        int k;
        logic [13:0] ad;
        logic [7:0] bh;
        logic [23:0] wd;
        ad = $urandom;
        bh = $urandom;
        wd = $urandom;
        ext_rd = $urandom;
        {i_XWRITE, i_XSPACE, i_XADDR, i_XBYTE_HI, i_XWDATA, i_WAIT_STATES} = {wr, sp, ad, bh, wd, w};
        i_XREQ = 1'b1;
        @(negedge I_CORE_CLK);
        i_XREQ = 1'b0;
        k = 0;
        while (o_XDONE !== 1'b1 && k < 40) begin
            if (k == 0 || k == w) begin
                `CHK(sel_v, exp_sel(sp))
                `CHK(o_ADDR_PIN[0], ad[0])
            end
            if (k == 0) begin
                `CHK({o_XBUSY, o_RD_N, o_WR_N}, {1'b1, wr, !wr})
                `CHK(o_COMBINED_MEM_SELECT_N, sp == 2'h2)
                `CHK(o_ADDR_PIN_OE_N, hm ? 14'h3ffe : 14'h0000)
                if (!hm) `CHK(o_ADDR_PIN, ad)
                if (sp == 2'h2) `CHK(o_DATA_PIN[23:16], bh)
                if (wr && sp == 2'h2) `CHK(hm ? o_DATA_PIN[15:8] : o_DATA_PIN[7:0], wd[7:0])
                if (wr && sp != 2'h2) `CHK(o_DATA_PIN[23:8], wd[23:8])
                if (wr && sp != 2'h2 && !hm) `CHK(o_DATA_PIN[7:0], wd[7:0])
            end
            @(negedge I_CORE_CLK);
            k++;
        end
        `CHK(k, exp_cyc(sp, w))
        if (!wr && sp == 2'h2) `CHK(o_XRDATA[7:0], hm ? ext_rd[15:8] : ext_rd[7:0])
        if (!wr && sp != 2'h2) `CHK(o_XRDATA[23:8], ext_rd[23:8])
        if (!wr && sp != 2'h2 && !hm) `CHK(o_XRDATA[7:0], ext_rd[7:0])
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        logic [15:0] v;
        logic [13:0] ad;
        void'($urandom(9100));
        do_reset(1'b0, 1'b0);
        // Every space both ways, slow spaces at fifteen wait states and fast ones at none, then random traffic.
        for (int i = 0; i < 8; i++)
            xacc(i[0], i[2:1], i[2] ? 4'hf : 4'h0);
        for (int i = 0; i < 24; i++)
            xacc($urandom_range(1), $urandom_range(3), $urandom_range(15));
        i_MODE_STRAP = 1'b1;
        repeat (3) @(negedge I_CORE_CLK);
        `CHK(o_HOST_MODE, 1'b0)
        $display("test full_mode done");
        for (int a = 0; a < 2; a++) begin
            do_reset(1'b1, a[0]);
            ad = $urandom;
            mpmux_host_model_i.latch({2'b01, ad});
            v = $urandom;
            mpmux_host_model_i.wr(v);
            `CHK(last, {2'b11, ad, v})
            v = $urandom;
            mpmux_host_model_i.wr(v);
            `CHK(last, {2'b11, ad + 14'h0001, v})
            i_IMEM_RDATA = $urandom;
            mpmux_host_model_i.latch({2'b00, ~ad});
            mpmux_host_model_i.rd(v);
            `CHK(v, i_IMEM_RDATA)
            `CHK(last[31:16], {2'b00, ~ad})
            for (int i = 0; i < 8; i++)
                xacc(i[0], i[2:1], $urandom_range(15));
            $display("test host_mode done");
        end
        final_report();
    end
endmodule // memory_port_mode_mux_tb
